/* File: rtl/bdm_map.svh */
// Address map constants for the banked data memory.
`ifndef BDM_MAP_SVH
`define BDM_MAP_SVH
`define BDM_ADDR_W 12
`define BDM_BANK_W 4
`define BDM_OFS_W 8
`define BDM_DATA_W 8
`define BDM_SPACE 4096
`define BDM_BANKS 16
`define BDM_BANK_BYTES 256
`define BDM_SFR_LO 12'hF80
`define BDM_SFR_HI 12'hFFF
`define BDM_GPR_LO 12'h000
`define BDM_SMALL_GPR_HI 12'h27F
`define BDM_SMALL_KRN_LO 12'h280
`define BDM_SMALL_KRN_HI 12'h2FF
`define BDM_LARGE_GPR_HI 12'h57F
`define BDM_LARGE_KRN_LO 12'h580
`define BDM_LARGE_KRN_HI 12'h5FF
`define BDM_RAM_DEPTH 1536
`define BDM_ACC_SPLIT 8'h80
`define BDM_BANK_RST 8'h00
`endif

/* File: rtl/bdm_pkg.sv */
// Types shared by the banked data memory files.
package bdm_pkg;
  typedef enum logic [1:0] {
    BDM_IDLE = 2'b00,
    BDM_MOVE = 2'b01
  } bdm_state_e;
  typedef enum logic [1:0] {
    BDM_DIRECT = 2'b00,
    BDM_ACCESS = 2'b01,
    BDM_INDIRECT = 2'b10,
    BDM_MOVE_OP = 2'b11
  } bdm_mode_e;
  typedef struct packed {
    logic valid;
    logic write;
    bdm_mode_e mode;
    logic [7:0] offset;
    logic [1:0] ptr_sel;
    logic [7:0] wdata;
  } bdm_req_s;
endpackage

/* File: rtl/bdm_ram.sv */
// Data storage with registered read port.
`timescale 1ns/1ps
`include "bdm_map.svh"
module bdm_ram (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [10:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [10:0] raddr,
  output logic [7:0] rdata_q
);
  logic [7:0] mem [0:`BDM_RAM_DEPTH-1];

  // Contents are never reset so that storage survives every reset.
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule

/* File: rtl/bdm_core.sv */
// Banked data memory with direct, access bank, indirect and move paths.
`timescale 1ns/1ps
`include "bdm_map.svh"
module bdm_core #(
  parameter bit LARGE = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire bdm_pkg::bdm_req_s req,
  input wire logic [11:0] move_dst,
  input wire logic bank_wr,
  input wire logic [7:0] bank_wdata,
  input wire logic [1:0] ptr_wr,
  input wire logic [11:0] ptr_wdata,
  input wire logic [7:0] sfr_rdata,
  output logic [7:0] bank_select_q,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  output logic busy_q,
  output logic [11:0] sfr_addr_q,
  output logic sfr_we_q,
  output logic [7:0] sfr_wdata_q
);
  bdm_pkg::bdm_state_e state_q;
  logic [11:0] ptr_q [0:1];
  logic [11:0] addr;
  logic [11:0] dst_q;
  logic [11:0] raddr_q;
  logic rd_pend_q;
  logic [7:0] ram_rdata;
  logic ram_we;
  logic [11:0] ram_waddr;
  logic [7:0] ram_wd;
  logic [7:0] rd_byte;

  ////////////////////////////////////////////////////////////////////////
  // Address classification, shared by both ports of the move.

  function automatic logic in_ram(input logic [11:0] a);
    logic [11:0] top;
    top = LARGE ? `BDM_LARGE_KRN_HI : `BDM_SMALL_KRN_HI;
    in_ram = (a <= top);
  endfunction

  function automatic logic in_sfr(input logic [11:0] a);
    in_sfr = (a >= `BDM_SFR_LO);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Address formation.

  always_comb begin
    unique case (req.mode)
      bdm_pkg::BDM_DIRECT: addr = {bank_select_q[3:0], req.offset};
      bdm_pkg::BDM_ACCESS: addr = (req.offset < `BDM_ACC_SPLIT) ?
        {4'h0, req.offset} : {4'hF, req.offset};
      bdm_pkg::BDM_INDIRECT: addr = ptr_q[req.ptr_sel[0]];
      bdm_pkg::BDM_MOVE_OP: addr = {req.wdata[3:0], req.offset};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Bank select and pointers; upper bank bits are not stored.

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bank_select_q <= `BDM_BANK_RST;
    end else if (bank_wr) begin
      bank_select_q <= {4'h0, bank_wdata[3:0]};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ptr
      always_ff @(posedge core_clk) begin
        if (rst) begin
          ptr_q[g] <= 12'h000;
        end else if (ptr_wr[g]) begin
          ptr_q[g] <= ptr_wdata;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Move sequencing: cycle one reads the source, cycle two writes it.
  // The source rides in wdata[3:0] over offset, so any byte can be copied.

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= bdm_pkg::BDM_IDLE;
      busy_q <= 1'b0;
      dst_q <= 12'h000;
    end else begin
      unique case (state_q)
        bdm_pkg::BDM_IDLE: begin
          if (req.valid && req.mode == bdm_pkg::BDM_MOVE_OP) begin
            state_q <= bdm_pkg::BDM_MOVE;
            busy_q <= 1'b1;
            dst_q <= move_dst;
          end
        end
        bdm_pkg::BDM_MOVE: begin
          state_q <= bdm_pkg::BDM_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path and the single write port.

  logic [11:0] rd_addr;
  assign rd_addr = addr;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_pend_q <= 1'b0;
      raddr_q <= 12'h000;
    end else begin
      rd_pend_q <= req.valid && !req.write && state_q == bdm_pkg::BDM_IDLE;
      raddr_q <= rd_addr;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (in_ram(raddr_q)) begin
      rd_byte = ram_rdata;
    end else if (in_sfr(raddr_q)) begin
      rd_byte = sfr_rdata;
    end
  end

  // Outside writes the port shows the read address to the special registers.
  always_comb begin
    ram_we = 1'b0;
    ram_waddr = rd_addr;
    ram_wd = req.wdata;
    if (state_q == bdm_pkg::BDM_MOVE) begin
      ram_we = in_ram(dst_q);
      ram_waddr = dst_q;
      ram_wd = rd_byte;
    end else if (req.valid && req.write &&
                 req.mode != bdm_pkg::BDM_MOVE_OP) begin
      ram_we = in_ram(addr);
      ram_waddr = addr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      sfr_addr_q <= 12'h000;
      sfr_we_q <= 1'b0;
      sfr_wdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_byte;
      rvalid_q <= rd_pend_q && state_q == bdm_pkg::BDM_IDLE;
      sfr_addr_q <= ram_waddr;
      sfr_we_q <= in_sfr(ram_waddr) && (state_q == bdm_pkg::BDM_MOVE ||
        (req.valid && req.write && req.mode != bdm_pkg::BDM_MOVE_OP));
      sfr_wdata_q <= ram_wd;
    end
  end

  bdm_ram u_ram (
    .core_clk(core_clk),
    .we(ram_we),
    .waddr(ram_waddr[10:0]),
    .wdata(ram_wd),
    .raddr(rd_addr[10:0]),
    .rdata_q(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  bank_high_zero_a: assert property (
    @(posedge core_clk) disable iff (rst) bank_select_q[7:4] == 4'h0)
    else $error("bank high bits set");
  bank_load_a: assert property (
    @(posedge core_clk) disable iff (rst)
    bank_wr |=> bank_select_q[3:0] == $past(bank_wdata[3:0]))
    else $error("bank select not loaded");
  unimpl_zero_a: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_pend_q && !in_ram(raddr_q) && !in_sfr(raddr_q) |=> rdata_q == 8'h00)
    else $error("unimplemented read not zero");
  move_two_a: assert property (
    @(posedge core_clk) disable iff (rst)
    state_q == bdm_pkg::BDM_IDLE && req.valid &&
    req.mode == bdm_pkg::BDM_MOVE_OP |=> busy_q ##1 !busy_q)
    else $error("move not two cycles");
  direct_addr_a: assert property (
    @(posedge core_clk) disable iff (rst)
    state_q == bdm_pkg::BDM_IDLE && req.valid && req.write &&
    req.mode == bdm_pkg::BDM_DIRECT |->
    ram_waddr == {bank_select_q[3:0], req.offset})
    else $error("direct address wrong");
  access_bank_a: assert property (
    @(posedge core_clk) disable iff (rst)
    req.mode == bdm_pkg::BDM_ACCESS |->
    addr[11:8] == (req.offset[7] ? 4'hF : 4'h0))
    else $error("access bank wrong");
  ptr_load_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ptr_wr[0] |=> ptr_q[0] == $past(ptr_wdata))
    else $error("pointer not loaded");
  sfr_range_a: assert property (
    @(posedge core_clk) disable iff (rst)
    sfr_we_q |-> sfr_addr_q >= `BDM_SFR_LO)
    else $error("sfr write low");
  cov_move_c: cover property (@(posedge core_clk) busy_q);
  cov_ind_c: cover property (@(posedge core_clk)
    req.valid && req.mode == bdm_pkg::BDM_INDIRECT);
  cov_sfr_c: cover property (@(posedge core_clk) sfr_we_q);
endmodule

/* File: tb/bdm_sfr_model.sv */
// Peripheral side model holding the special function registers.
`timescale 1ns/1ps
module bdm_sfr_model (
  input wire logic core_clk,
  input wire logic [11:0] sfr_addr_q,
  input wire logic sfr_we_q,
  input wire logic [7:0] sfr_wdata_q,
  output logic [7:0] sfr_rdata,
  output logic [11:0] last_addr,
  output logic [7:0] last_data
);
  logic [7:0] top_q;
  initial begin
    top_q = 8'h00;
    last_addr = 12'h000;
    last_data = 8'h00;
  end
  always @(posedge core_clk) begin
    if (sfr_we_q) begin
      last_addr <= sfr_addr_q;
      last_data <= sfr_wdata_q;
      if (sfr_addr_q == 12'hFFF) top_q <= sfr_wdata_q;
    end
  end
  // Only the top slot exists, so every other slot reads zero.
  assign sfr_rdata = (sfr_addr_q == 12'hFFF) ? top_q : 8'h00;
endmodule

/* File: tb/bdm_core_tb.sv */
// Self-checking testbench for the banked data memory.
`timescale 1ns/1ps
module bdm_core_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  bdm_pkg::bdm_req_s req = '0;
  logic [11:0] move_dst = 12'h000;
  logic bank_wr = 1'b0;
  logic [7:0] bank_wdata = 8'h00;
  logic [1:0] ptr_wr = 2'b00;
  logic [11:0] ptr_wdata = 12'h000;
  logic [7:0] sfr_rdata, bank_select_q, rdata_q, sfr_wdata_q, last_data;
  logic rvalid_q, busy_q, sfr_we_q;
  logic [11:0] sfr_addr_q, last_addr;
  logic [7:0] rdata_s;
  logic rvalid_s;
  logic [1:0] psel = 2'b01;
  logic [11:0] tbl [5] = '{12'h000, 12'h27F, 12'h280, 12'h57F, 12'h5FF};
  int errors = 0;
  int compares = 0;
  always #4 core_clk = ~core_clk;
  bdm_core #(.LARGE(1'b1)) i_dut (.core_clk(core_clk), .rst(rst),
    .req(req), .move_dst(move_dst), .bank_wr(bank_wr),
    .bank_wdata(bank_wdata), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata),
    .sfr_rdata(sfr_rdata), .bank_select_q(bank_select_q),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .busy_q(busy_q),
    .sfr_addr_q(sfr_addr_q), .sfr_we_q(sfr_we_q),
    .sfr_wdata_q(sfr_wdata_q));
  bdm_core #(.LARGE(1'b0)) i_dut_small (.core_clk(core_clk), .rst(rst),
    .req(req), .move_dst(move_dst), .bank_wr(bank_wr),
    .bank_wdata(bank_wdata), .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata),
    .sfr_rdata(sfr_rdata), .bank_select_q(), .rdata_q(rdata_s),
    .rvalid_q(rvalid_s), .busy_q(), .sfr_addr_q(), .sfr_we_q(),
    .sfr_wdata_q());
  bdm_sfr_model i_sfr (.core_clk(core_clk), .sfr_addr_q(sfr_addr_q),
    .sfr_we_q(sfr_we_q), .sfr_wdata_q(sfr_wdata_q),
    .sfr_rdata(sfr_rdata), .last_addr(last_addr), .last_data(last_data));
  task automatic final_report();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [11:0] e,
                     input logic [11:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic ptr(input logic [11:0] a);
    ptr_wr = 2'b10;
    ptr_wdata = a;
    tick();
    ptr_wr = 2'b00;
  endtask
  task automatic acc(input bdm_pkg::bdm_mode_e m, input logic w,
                     input logic [7:0] ofs, input logic [7:0] d);
    req = '{1'b1, w, m, ofs, psel, d};
    tick();
    req = '0;
    // The idle cycle keeps two requests from touching at one time step.
    tick();
  endtask
  // Read answers two edges after the request, flagged by rvalid_q.
  task automatic rd(input bdm_pkg::bdm_mode_e m, input logic [7:0] ofs,
                    input logic [7:0] e, input string what);
    acc(m, 1'b0, ofs, 8'h00);
    chk(what, {4'h1, e}, {3'h0, rvalid_q, rdata_q});
  endtask
  initial begin
    #20000;
    errors++;
    final_report();
  end
  initial begin
    repeat (5) tick();
    rst = 1'b0;
    chk("bank reset", 12'h000, {4'h0, bank_select_q});
    bank_wr = 1'b1;
    bank_wdata = 8'hF3;
    tick();
    bank_wr = 1'b0;
    chk("bank select", 12'h003, {4'h0, bank_select_q});
    acc(bdm_pkg::BDM_DIRECT, 1'b1, 8'h10, 8'hA5);
    acc(bdm_pkg::BDM_ACCESS, 1'b1, 8'h10, 8'h3C);
    ptr(12'h310);
    rd(bdm_pkg::BDM_INDIRECT, 8'h00, 8'hA5, "bank3 ptr");
    rd(bdm_pkg::BDM_DIRECT, 8'h10, 8'hA5, "bank3 direct");
    ptr_wr = 2'b01;
    ptr_wdata = 12'h010;
    tick();
    ptr_wr = 2'b00;
    psel = 2'b00;
    rd(bdm_pkg::BDM_INDIRECT, 8'h00, 8'h3C, "access bank");
    psel = 2'b01;
    foreach (tbl[i]) begin
      ptr(tbl[i]);
      acc(bdm_pkg::BDM_INDIRECT, 1'b1, 8'h00, tbl[i][7:0] ^ 8'h5A);
      rd(bdm_pkg::BDM_INDIRECT, 8'h00, tbl[i][7:0] ^ 8'h5A, "edge");
    end
    ptr(12'h600);
    acc(bdm_pkg::BDM_INDIRECT, 1'b1, 8'h00, 8'hFF);
    rd(bdm_pkg::BDM_INDIRECT, 8'h00, 8'h00, "unimplemented");
    ptr(12'h2FF);
    acc(bdm_pkg::BDM_INDIRECT, 1'b1, 8'h00, 8'hC3);
    rd(bdm_pkg::BDM_INDIRECT, 8'h00, 8'hC3, "large 2ff");
    chk("small kernel", 12'h1C3, {3'h0, rvalid_s, rdata_s});
    ptr(12'h300);
    acc(bdm_pkg::BDM_INDIRECT, 1'b1, 8'h00, 8'h96);
    rd(bdm_pkg::BDM_INDIRECT, 8'h00, 8'h96, "large 300");
    chk("small 300", 12'h100, {3'h0, rvalid_s, rdata_s});
    move_dst = 12'h57E;
    req = '{1'b1, 1'b0, bdm_pkg::BDM_MOVE_OP, 8'h10, psel, 8'h00};
    tick();
    req = '0;
    chk("move busy", 12'h001, {11'h0, busy_q});
    tick();
    chk("move done", 12'h000, {11'h0, busy_q});
    ptr(12'h57E);
    rd(bdm_pkg::BDM_INDIRECT, 8'h00, 8'h3C, "moved byte");
    ptr(12'hFFF);
    acc(bdm_pkg::BDM_INDIRECT, 1'b1, 8'h00, 8'h77);
    chk("sfr addr", 12'hFFF, last_addr);
    chk("sfr data", 12'h077, {4'h0, last_data});
    rd(bdm_pkg::BDM_INDIRECT, 8'h00, 8'h77, "sfr read");
    ptr(12'hF85);
    rd(bdm_pkg::BDM_INDIRECT, 8'h00, 8'h00, "sfr unused");
    // A second reset must leave stored bytes alone.
    rst = 1'b1;
    tick();
    tick();
    rst = 1'b0;
    ptr(12'h57E);
    rd(bdm_pkg::BDM_INDIRECT, 8'h00, 8'h3C, "kept byte");
    final_report();
  end
endmodule
